//--- rtl/ssli_params.svh
// Register map, field positions and timing counts of the serial line interface
`ifndef SSLI_PARAMS_SVH
`define SSLI_PARAMS_SVH
`define IDX_RX_CTRL 2'h0
`define IDX_RX_BUF 2'h1
`define IDX_PARAM 2'h1
`define IDX_TX_CTRL 2'h2
`define IDX_TX_BUF 2'h3
`define RC_DTR 1
`define RC_RTS 2
`define RC_HUNT 4
`define RC_RXIE 6
`define RC_RXDONE 7
`define RC_SYNCED 8
`define RC_WMASK 16'h0056
`define RC_MODEM 16'h0006
`define TC_MDATA 0
`define TC_SSCLK 1
`define TC_MODE_LO 2
`define TC_MODE_HI 3
`define TC_SEND 4
`define TC_HDX 5
`define TC_TXDONE 7
`define TC_MRST 8
`define TC_MSEL 9
`define TC_BREAK 10
`define TC_RXMON 11
`define TC_DNA 12
`define TC_WMASK 16'h077F
`define RB_PERR 12
`define RB_FERR 13
`define RB_OVRN 14
`define PR_LEN_LO 8
`define PR_LEN_HI 9
`define PR_PAREN 10
`define PR_PARODD 11
`define PR_MODE_LO 12
`define PR_MODE_HI 13
`define CLEAR_CYCLES 3'h4
`define TEST_DIV 4'h8
`define RXBUF_IDLE 8'hFF
`define BIT_CNT_TOP 4'h9
`endif

//--- rtl/ssli_pkg.sv
// Types shared by the serial line interface files
package ssli_pkg;
  typedef enum logic [1:0] {MAINT_NORMAL = 2'b00, MAINT_INT_LOOP = 2'b01,
    MAINT_EXT_LOOP = 2'b10, MAINT_SYS_TEST = 2'b11} maint_mode_e;
  typedef enum logic [1:0] {LINE_ISO = 2'b00, LINE_INT_SYNC = 2'b01,
    LINE_EXT_SYNC = 2'b10} line_mode_e;
  typedef enum logic [2:0] {RX_OFF = 3'b000, RX_HUNT = 3'b001, RX_VERIFY = 3'b010,
    RX_FRAME = 3'b011, RX_STOP = 3'b100} rx_state_e;
endpackage : ssli_pkg

//--- rtl/line_transmitter.sv
// Serial transmitter with holding buffer and own parameter copy
`timescale 1ns/100ps
`default_nettype none
`include "ssli_params.svh"
module line_transmitter (
  input wire logic i_clock,
  input wire logic i_clear,
  input wire logic i_tick,
  input wire logic i_send,
  input wire logic i_break,
  input wire logic i_load,
  input wire logic [7:0] i_data,
  input wire logic i_param_load,
  input wire logic [15:0] i_param,
  output logic o_serial,
  output logic o_tx_done,
  output logic o_dna
);
  import ssli_pkg::*;
  logic [15:0] param;
  logic [7:0] hold;
  logic full;
  logic [10:0] shreg;
  logic [3:0] left;
  logic iso;
  logic [3:0] nbits;
  logic [7:0] mask;
  logic fetch_data;
  logic fetch_sync;
  logic [10:0] first_frame;

  function automatic logic [10:0] frame(input logic [7:0] d, input logic [15:0] p);
    logic [7:0] m;
    logic [3:0] dp;
    logic [10:0] f;
    m = 8'hFF >> (2'h3 - p[`PR_LEN_HI:`PR_LEN_LO]);
    dp = 4'h5 + {2'h0, p[`PR_LEN_HI:`PR_LEN_LO]};
    f = {3'h0, d & m};
    if (p[`PR_PAREN]) begin
      f = f | ({10'h000, (^(d & m)) ^ p[`PR_PARODD]} << dp);
      dp = dp + 4'h1;
    end
    if (p[`PR_MODE_HI:`PR_MODE_LO] == LINE_ISO) begin
      f = (f << 1) | (11'h001 << (dp + 4'h1));
    end
    return f;
  endfunction : frame

  assign iso = (param[`PR_MODE_HI:`PR_MODE_LO] == LINE_ISO);
  assign mask = 8'hFF >> (2'h3 - param[`PR_LEN_HI:`PR_LEN_LO]);
  assign nbits = 4'h5 + {2'h0, param[`PR_LEN_HI:`PR_LEN_LO]} + {3'h0, param[`PR_PAREN]}
    + (iso ? 4'h2 : 4'h0);
  assign fetch_data = i_tick && (left == 4'h0) && i_send && full;
  assign fetch_sync = i_tick && (left == 4'h0) && i_send && !full && !iso;
  assign first_frame = frame(fetch_data ? hold : param[7:0], param);

  // Parameter copy loaded together with the receiver copy
  always_ff @(posedge i_clock) begin
    if (i_clear) begin
      param <= 16'h0000;
    end else if (i_param_load) begin
      param <= i_param;
    end
  end

  // Holding buffer
  always_ff @(posedge i_clock) begin
    if (i_clear) begin
      hold <= 8'h00;
      full <= 1'b0;
    end else if (i_load) begin
      hold <= i_data & mask;
      full <= 1'b1;
    end else if (fetch_data) begin
      full <= 1'b0;
    end
  end

  // Shifter; idle or paused line marks
  always_ff @(posedge i_clock) begin
    if (i_clear) begin
      shreg <= 11'h000;
      left <= 4'h0;
      o_serial <= 1'b1;
    end else if (i_tick) begin
      if (left != 4'h0) begin
        o_serial <= shreg[0] | i_break;
        shreg <= shreg >> 1;
        left <= left - 4'h1;
      end else if (fetch_data || fetch_sync) begin
        shreg <= first_frame >> 1;
        o_serial <= first_frame[0] | i_break;
        left <= nbits - 4'h1;
      end else begin
        o_serial <= 1'b1;
      end
    end
  end

  // Done flag frozen while send is clear; set wins over load
  always_ff @(posedge i_clock) begin
    if (i_clear) begin
      o_tx_done <= 1'b1;
    end else if (fetch_data) begin
      o_tx_done <= 1'b1;
    end else if (i_load && i_send) begin
      o_tx_done <= 1'b0;
    end
  end

  // Fill character indication
  always_ff @(posedge i_clock) begin
    if (i_clear) begin
      o_dna <= 1'b1;
    end else if (fetch_sync) begin
      o_dna <= 1'b1;
    end else if (fetch_data) begin
      o_dna <= 1'b0;
    end
  end
endmodule : line_transmitter
`default_nettype wire

//--- rtl/sync_serial_line_interface.sv
// Serial line interface: bus slave, clear, clocks, input select, receiver
// Function
// - Software sets the master reset bit to reinitialize the whole interface.
// - Writing the transmit holding buffer starts transmission of that character.
// - With send set the transmitter shifts the character and raises transmit done.
// - Send cleared: finish character, then mark; done flag frozen.
// - Synchronous mode underrun sends the sync character.
// - Isochronous mode underrun pauses until the buffer is written.
// - Receiver accepts data only while hunt enable is set.
// - Once synced, frame next character into buffer and set receive done.
// - Receive done raises the receiver interrupt request.
// - New character before read overwrites buffer and sets overrun.
// - Parameter write loads identical receiver and transmitter copies.
// - Decoder makes separate load strobes for each writable register.
// - Reads use driver enable and two address lines to pick the register.
// - Bus init or master reset clears everything; no bus reply meanwhile.
// - Jumper removed: clearing leaves modem control outputs unchanged; the code keeps them only on master reset, bus init clears them.
// - Master requests a transfer; slave signals its completion.
// - Control registers are 16-bit, word or byte writable.
// - Clocks: modem in normal and external loop, single step in internal loop, internal in system test.
// - Send with half duplex blocks the receive clock.
// - External loop drives a clock out for looping back.
// - Receive source: modem, transmitter, or maintenance bit per mode.
// - In loop modes the receive input level reads in transmit control.
// - Clear: receiver idle, buffer all ones, sync window and flags cleared.
// - Clear: transmitter idle, marking, output flags set.
// - Parameters: mode, length five to eight, parity, sense, sync character.
// - Internal sync needs two back-to-back sync characters before framing.
//
// The implementer's own choices: the register offsets and the Avalon-MM slave port.
`timescale 1ns/100ps
`default_nettype none
`include "ssli_params.svh"
module sync_serial_line_interface (
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic [1:0] i_address,
  input wire logic i_read,
  input wire logic i_write,
  input wire logic [31:0] i_writedata,
  input wire logic [3:0] i_byteenable,
  output logic [31:0] o_readdata,
  output logic o_waitrequest,
  input wire logic i_serial_data_in,
  input wire logic i_modem_tx_clock,
  input wire logic i_modem_rx_clock,
  input wire logic i_optional_clear_jumper,
  output logic o_serial_data_out,
  output logic o_data_term_ready,
  output logic o_request_to_send,
  output logic o_loopback_clock_out,
  output logic o_rx_irq
);
  import ssli_pkg::*;
  logic [3:0] sync1;
  logic [3:0] sync2;
  logic [1:0] clk_prev;
  logic [2:0] clear_count;
  logic main_clear_pulse;
  logic modem_ctrl_clear_pulse;
  logic accept;
  logic driver_enable;
  logic read_select_hi;
  logic read_select_lo;
  logic rx_ctrl_load_strobe;
  logic tx_ctrl_load_strobe;
  logic param_load_strobe;
  logic tx_buffer_load_strobe;
  logic rx_buf_read;
  logic [15:0] receive_control_reg;
  logic [15:0] transmit_control_reg;
  logic [15:0] rx_param;
  logic [15:0] rc_view;
  logic [15:0] tc_view;
  logic [15:0] rb_view;
  logic ss_prev;
  logic [3:0] test_count;
  logic test_tick;
  logic ss_edge;
  logic tx_tick;
  logic rx_tick;
  logic rx_tick_g;
  logic rx_in;
  logic receive_line_monitor;
  logic tx_line;
  logic tx_done;
  logic tx_dna;
  maint_mode_e maint;
  rx_state_e state;
  logic [8:0] shreg;
  logic [8:0] window;
  logic [3:0] cnt;
  logic [7:0] receive_holding_buffer;
  logic perr;
  logic ferr;
  logic rx_done;
  logic overrun_flag;
  logic receiver_synced;
  logic hunt_enable_bit;
  logic half_duplex_bit;
  logic maintenance_serial_bit;
  logic send;
  logic [3:0] rdbits;
  logic [7:0] rmask;
  logic [8:0] sh_next;
  logic [8:0] win_next;
  logic [8:0] expect_sync;
  logic last_bit;
  logic deliver;
  logic [7:0] rdata;
  logic rpar;

  function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] wd,
    input logic [3:0] be, input logic [15:0] wmask);
    logic [15:0] n;
    n = old;
    if (be[0]) begin
      n[7:0] = wd[7:0];
    end
    if (be[1]) begin
      n[15:8] = wd[15:8];
    end
    return n & wmask;
  endfunction : merge

  // Two-stage synchronisers: serial in, tx clock, rx clock, jumper
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      sync1 <= 4'h0;
      sync2 <= 4'h0;
      clk_prev <= 2'h0;
    end else begin
      sync1 <= {i_optional_clear_jumper, i_modem_rx_clock, i_modem_tx_clock, i_serial_data_in};
      sync2 <= sync1;
      clk_prev <= sync2[2:1];
    end
  end

  // Clear sequencer for bus init and master reset
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      clear_count <= `CLEAR_CYCLES;
    end else if (tx_ctrl_load_strobe && i_byteenable[1] && i_writedata[`TC_MRST]) begin
      clear_count <= `CLEAR_CYCLES;
    end else if (clear_count != 3'h0) begin
      clear_count <= clear_count - 3'h1;
    end
  end
  assign main_clear_pulse = (clear_count != 3'h0);
  assign modem_ctrl_clear_pulse = main_clear_pulse && sync2[3];

  // Avalon slave handshake; no reply while clearing
  assign driver_enable = i_read && !i_write && o_waitrequest && !main_clear_pulse;
  assign accept = (i_read || i_write) && !o_waitrequest;
  assign read_select_hi = i_address[1];
  assign read_select_lo = i_address[0];
  assign rx_ctrl_load_strobe = accept && i_write && (i_address == `IDX_RX_CTRL);
  assign param_load_strobe = accept && i_write && (i_address == `IDX_PARAM);
  assign tx_ctrl_load_strobe = accept && i_write && (i_address == `IDX_TX_CTRL);
  assign tx_buffer_load_strobe = accept && i_write && (i_address == `IDX_TX_BUF);
  assign rx_buf_read = accept && i_read && (i_address == `IDX_RX_BUF);

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      o_waitrequest <= 1'b1;
    end else begin
      o_waitrequest <= !((i_read || i_write) && o_waitrequest && !main_clear_pulse);
    end
  end

  // Read views of the registers
  always_comb begin
    rc_view = receive_control_reg;
    rc_view[`RC_RXDONE] = rx_done;
    rc_view[`RC_SYNCED] = receiver_synced;
    tc_view = transmit_control_reg;
    tc_view[`TC_TXDONE] = tx_done;
    tc_view[`TC_RXMON] = receive_line_monitor;
    tc_view[`TC_DNA] = tx_dna;
    rb_view = {8'h00, receive_holding_buffer};
    rb_view[`RB_PERR] = perr;
    rb_view[`RB_FERR] = ferr;
    rb_view[`RB_OVRN] = overrun_flag;
  end

  // Output multiplexer steered by the two address lines
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      o_readdata <= 32'h00000000;
    end else if (driver_enable) begin
      unique case ({read_select_hi, read_select_lo})
        `IDX_RX_CTRL: o_readdata <= {16'h0000, rc_view};
        `IDX_RX_BUF: o_readdata <= {16'h0000, rb_view};
        `IDX_TX_CTRL: o_readdata <= {16'h0000, tc_view};
        `IDX_TX_BUF: o_readdata <= 32'h00000000;
      endcase
    end
  end

  // Receive control; modem bits survive a master reset without the jumper, bus init clears them
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      receive_control_reg <= 16'h0000;
    end else if (main_clear_pulse) begin
      receive_control_reg <= modem_ctrl_clear_pulse ? 16'h0000
        : (receive_control_reg & `RC_MODEM);
    end else if (rx_ctrl_load_strobe) begin
      receive_control_reg <= merge(receive_control_reg, i_writedata, i_byteenable, `RC_WMASK);
    end
  end

  // Transmit control; clearing also drops the master reset bit
  always_ff @(posedge i_clock) begin
    if (!i_rst_n || main_clear_pulse) begin
      transmit_control_reg <= 16'h0000;
    end else if (tx_ctrl_load_strobe) begin
      transmit_control_reg <= merge(transmit_control_reg, i_writedata, i_byteenable, `TC_WMASK);
    end
  end

  // Receiver parameter copy
  always_ff @(posedge i_clock) begin
    if (!i_rst_n || main_clear_pulse) begin
      rx_param <= 16'h0000;
    end else if (param_load_strobe) begin
      rx_param <= i_writedata[15:0];
    end
  end

  assign maint = maint_mode_e'(transmit_control_reg[`TC_MODE_HI:`TC_MODE_LO]);
  assign send = transmit_control_reg[`TC_SEND];
  assign half_duplex_bit = transmit_control_reg[`TC_HDX];
  assign maintenance_serial_bit = transmit_control_reg[`TC_MDATA];
  assign hunt_enable_bit = receive_control_reg[`RC_HUNT];

  // Single step edge and internal test clock divider
  always_ff @(posedge i_clock) begin
    if (!i_rst_n || main_clear_pulse) begin
      ss_prev <= 1'b0;
      test_count <= 4'h0;
    end else begin
      ss_prev <= transmit_control_reg[`TC_SSCLK];
      test_count <= test_tick ? 4'h0 : test_count + 4'h1;
    end
  end
  assign test_tick = (test_count == `TEST_DIV - 4'h1);
  assign ss_edge = transmit_control_reg[`TC_SSCLK] && !ss_prev;

  // Clock and receive data selection per maintenance mode
  always_comb begin
    tx_tick = 1'b0;
    rx_tick = 1'b0;
    rx_in = sync2[0];
    receive_line_monitor = 1'b0;
    unique case (maint)
      MAINT_NORMAL: begin
        tx_tick = sync2[1] && !clk_prev[0];
        rx_tick = sync2[2] && !clk_prev[1];
        rx_in = sync2[0];
      end
      MAINT_INT_LOOP: begin
        tx_tick = ss_edge;
        rx_tick = ss_edge;
        rx_in = transmit_control_reg[`TC_MSEL] ? maintenance_serial_bit : tx_line;
        receive_line_monitor = rx_in;
      end
      MAINT_EXT_LOOP: begin
        tx_tick = sync2[1] && !clk_prev[0];
        rx_tick = sync2[2] && !clk_prev[1];
        rx_in = transmit_control_reg[`TC_MSEL] ? maintenance_serial_bit : sync2[0];
        receive_line_monitor = rx_in;
      end
      MAINT_SYS_TEST: begin
        tx_tick = test_tick;
        rx_tick = test_tick;
        rx_in = tx_line;
      end
    endcase
  end
  assign rx_tick_g = rx_tick && !(send && half_duplex_bit);

  line_transmitter transmitter (
    .i_clock(i_clock),
    .i_clear(!i_rst_n || main_clear_pulse),
    .i_tick(tx_tick),
    .i_send(send),
    .i_break(transmit_control_reg[`TC_BREAK]),
    .i_load(tx_buffer_load_strobe),
    .i_data(i_writedata[7:0]),
    .i_param_load(param_load_strobe),
    .i_param(i_writedata[15:0]),
    .o_serial(tx_line),
    .o_tx_done(tx_done),
    .o_dna(tx_dna)
  );

  // Receiver framing helpers
  always_comb begin
    rmask = 8'hFF >> (2'h3 - rx_param[`PR_LEN_HI:`PR_LEN_LO]);
    rdbits = 4'h5 + {2'h0, rx_param[`PR_LEN_HI:`PR_LEN_LO]} + {3'h0, rx_param[`PR_PAREN]};
    sh_next = {rx_in, shreg[8:1]};
    win_next = {rx_in, window[8:1]} >> (`BIT_CNT_TOP - rdbits);
    expect_sync = {1'b0, rx_param[7:0] & rmask};
    if (rx_param[`PR_PAREN]) begin
      expect_sync = expect_sync | ({8'h00, (^(rx_param[7:0] & rmask)) ^ rx_param[`PR_PARODD]}
        << (rdbits - 4'h1));
    end
    rdata = 8'(sh_next >> (`BIT_CNT_TOP - rdbits)) & rmask;
    rpar = (sh_next >> (`BIT_CNT_TOP - rdbits)) >> (rdbits - 4'h1) != 9'h000;
    last_bit = (cnt == rdbits - 4'h1);
    deliver = hunt_enable_bit && rx_tick_g && ((state == RX_FRAME && last_bit
      && rx_param[`PR_MODE_HI:`PR_MODE_LO] != LINE_ISO) || state == RX_STOP);
  end
  assign receiver_synced = (state == RX_FRAME) || (state == RX_STOP);

  // Receiver sequencer
  always_ff @(posedge i_clock) begin
    if (!i_rst_n || main_clear_pulse) begin
      state <= RX_OFF;
      shreg <= 9'h000;
      window <= 9'h000;
      cnt <= 4'h0;
    end else if (!hunt_enable_bit) begin
      state <= RX_OFF;
      window <= 9'h000;
    end else if (state == RX_OFF) begin
      state <= (rx_param[`PR_MODE_HI:`PR_MODE_LO] == LINE_EXT_SYNC) ? RX_FRAME : RX_HUNT;
      cnt <= 4'h0;
    end else if (rx_tick_g) begin
      window <= {rx_in, window[8:1]};
      unique case (state)
        RX_HUNT: begin
          cnt <= 4'h0;
          if (rx_param[`PR_MODE_HI:`PR_MODE_LO] == LINE_ISO) begin
            state <= rx_in ? RX_HUNT : RX_FRAME;
          end else if (win_next == expect_sync) begin
            state <= RX_VERIFY;
          end
        end
        RX_VERIFY: begin
          cnt <= last_bit ? 4'h0 : cnt + 4'h1;
          if (last_bit) begin
            state <= (win_next == expect_sync) ? RX_FRAME : RX_HUNT;
          end
        end
        RX_FRAME: begin
          shreg <= sh_next;
          cnt <= last_bit ? 4'h0 : cnt + 4'h1;
          if (last_bit && rx_param[`PR_MODE_HI:`PR_MODE_LO] == LINE_ISO) begin
            state <= RX_STOP;
          end
        end
        RX_STOP: state <= RX_HUNT;
        default: state <= RX_OFF;
      endcase
    end
  end

  // Receive holding buffer and its error bits
  always_ff @(posedge i_clock) begin
    if (!i_rst_n || main_clear_pulse) begin
      receive_holding_buffer <= `RXBUF_IDLE;
      perr <= 1'b0;
      ferr <= 1'b0;
    end else if (deliver) begin
      receive_holding_buffer <= (state == RX_STOP) ? 8'(shreg >> (`BIT_CNT_TOP - rdbits)) & rmask : rdata;
      perr <= rx_param[`PR_PAREN] && (((state == RX_STOP) ? (^(shreg >> (`BIT_CNT_TOP - rdbits)))
        : (^rdata ^ rpar)) != rx_param[`PR_PARODD]);
      ferr <= (state == RX_STOP) && !rx_in;
    end
  end

  // Done and overrun flags; a new character wins over the read clear
  always_ff @(posedge i_clock) begin
    if (!i_rst_n || main_clear_pulse) begin
      rx_done <= 1'b0;
      overrun_flag <= 1'b0;
    end else if (deliver) begin
      rx_done <= 1'b1;
      overrun_flag <= rx_done && !rx_buf_read;
    end else if (rx_buf_read) begin
      rx_done <= 1'b0;
      overrun_flag <= 1'b0;
    end
  end

  // Registered line side outputs
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      o_serial_data_out <= 1'b1;
      o_data_term_ready <= 1'b0;
      o_request_to_send <= 1'b0;
      o_loopback_clock_out <= 1'b0;
      o_rx_irq <= 1'b0;
    end else begin
      o_serial_data_out <= tx_line;
      o_data_term_ready <= receive_control_reg[`RC_DTR];
      o_request_to_send <= receive_control_reg[`RC_RTS];
      o_loopback_clock_out <= (maint == MAINT_EXT_LOOP) && transmit_control_reg[`TC_SSCLK];
      o_rx_irq <= rx_done && receive_control_reg[`RC_RXIE];
    end
  end
endmodule : sync_serial_line_interface
`default_nettype wire

//--- verif/sync_serial_line_interface_sva.sv
// Checker of the serial line interface bus and line ports
`timescale 1ns/100ps
`default_nettype none
module ssli_sva (
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic [1:0] i_address,
  input wire logic i_read,
  input wire logic i_write,
  input wire logic [31:0] i_writedata,
  input wire logic [3:0] i_byteenable,
  input wire logic [31:0] o_readdata,
  input wire logic o_waitrequest,
  input wire logic o_serial_data_out,
  input wire logic o_data_term_ready,
  input wire logic o_rx_irq
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);
  property p_wait_one; !o_waitrequest |=> o_waitrequest; endproperty
  a_wait_one: assert property (p_wait_one) else $error("reply longer than one cycle");
  property p_clear_hold; $rose(i_rst_n) |-> o_waitrequest [*3]; endproperty
  a_clear_hold: assert property (p_clear_hold) else $error("reply during clear");
  property p_mark; $rose(i_rst_n) |-> o_serial_data_out; endproperty
  a_mark: assert property (p_mark) else $error("line not marking after clear");
  property p_answer; (i_read || i_write) |-> ##[0:16] !o_waitrequest; endproperty
  a_answer: assert property (p_answer) else $error("no reply to request");
  property p_spur; !o_waitrequest |-> $past(i_read || i_write); endproperty
  a_spur: assert property (p_spur) else $error("reply without request");
  property p_idx3; i_read && i_address == 2'h3 && !o_waitrequest |-> o_readdata == 32'h0; endproperty
  a_idx3: assert property (p_idx3) else $error("unmapped read not zero");
  property p_upper; o_readdata[31:16] == 16'h0; endproperty
  a_upper: assert property (p_upper) else $error("read data above 16 bits");
  property p_dtr;
    i_write && !o_waitrequest && i_address == 2'h0 && i_byteenable[0]
      |-> ##2 o_data_term_ready == $past(i_writedata[1], 2);
  endproperty
  a_dtr: assert property (p_dtr) else $error("terminal ready not written");
  property p_irq_off;
    i_write && !o_waitrequest && i_address == 2'h0 && i_byteenable[0] && !i_writedata[6] |-> ##2 !o_rx_irq;
  endproperty
  a_irq_off: assert property (p_irq_off) else $error("interrupt while disabled");
endmodule : ssli_sva
bind sync_serial_line_interface ssli_sva u_sva (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_address(i_address),
  .i_read(i_read), .i_write(i_write), .i_writedata(i_writedata), .i_byteenable(i_byteenable),
  .o_readdata(o_readdata), .o_waitrequest(o_waitrequest), .o_serial_data_out(o_serial_data_out),
  .o_data_term_ready(o_data_term_ready), .o_rx_irq(o_rx_irq));
`default_nettype wire

//--- verif/modem_model.sv
// Modem model: bit clock and looped line
`timescale 1ns/100ps
`default_nettype none
module modem_model (
  input wire logic i_enable,
  input wire logic i_tx_line,
  output logic o_bit_clock,
  output logic o_rx_line
);
  initial begin
    o_bit_clock = 1'b0;
    o_rx_line = 1'b1;
    #3;
    forever begin
      #24;
      if (i_enable) begin
        o_bit_clock = ~o_bit_clock;
        if (!o_bit_clock) begin
          o_rx_line = i_tx_line;
        end
      end else begin
        o_bit_clock = 1'b0;
        o_rx_line = ~o_rx_line;
      end
    end
  end
endmodule : modem_model
`default_nettype wire

//--- verif/sync_serial_line_interface_tb.sv
// Testbench of the serial line interface
`timescale 1ns/100ps
`default_nettype none
`include "ssli_params.svh"
module sync_serial_line_interface_tb;
  logic i_clock, i_rst_n, i_read, i_write, jumper, mdm_en;
  logic [1:0] i_address;
  logic [31:0] i_writedata, o_readdata, seed;
  logic [3:0] i_byteenable;
  logic o_waitrequest, ser_out, dtr, rts, lclk, irq, bclk, rx_line;
  logic [15:0] rd, exp_rc;
  logic [7:0] ch;
  int errors, cmp_count, cyc;
  sync_serial_line_interface u_dut (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_address(i_address),
    .i_read(i_read), .i_write(i_write), .i_writedata(i_writedata), .i_byteenable(i_byteenable),
    .o_readdata(o_readdata), .o_waitrequest(o_waitrequest), .i_serial_data_in(rx_line),
    .i_modem_tx_clock(bclk), .i_modem_rx_clock(bclk), .i_optional_clear_jumper(jumper),
    .o_serial_data_out(ser_out), .o_data_term_ready(dtr), .o_request_to_send(rts),
    .o_loopback_clock_out(lclk), .o_rx_irq(irq));
  modem_model u_modem (.i_enable(mdm_en), .i_tx_line(ser_out), .o_bit_clock(bclk), .o_rx_line(rx_line));
  initial begin
    i_clock = 1'b0;
    forever #2 i_clock = ~i_clock;
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction : xs
  function automatic logic [15:0] lanes(input logic [3:0] be);
    return {{8{be[1]}}, {8{be[0]}}};
  endfunction : lanes
  task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask : check
  task automatic results();
    $display("errors %0d comparisons %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : results
  task automatic wr(input logic [1:0] a, input logic [15:0] d, input logic [3:0] be);
    @(posedge i_clock);
    i_address <= a;
    i_writedata <= {16'h0000, d};
    i_byteenable <= be;
    i_write <= 1'b1;
    do @(posedge i_clock); while (o_waitrequest !== 1'b0);
    i_write <= 1'b0;
  endtask : wr
  task automatic rdr(input logic [1:0] a);
    @(posedge i_clock);
    i_address <= a;
    i_read <= 1'b1;
    do @(posedge i_clock); while (o_waitrequest !== 1'b0);
    rd = o_readdata[15:0];
    i_read <= 1'b0;
  endtask : rdr
  task automatic wait_rx();
    for (int n = 0; n < 300; n++) begin
      rdr(`IDX_RX_CTRL);
      if (rd[`RC_RXDONE] === 1'b1) break;
    end
  endtask : wait_rx
  task automatic mrst();
    wr(`IDX_TX_CTRL, 16'h0100, 4'h2);
  endtask : mrst
  always @(posedge i_clock) begin
    cyc++;
    if (cyc == 40000) begin
      errors++;
      results();
    end
  end
  initial begin
    i_rst_n = 1'b0;
    i_read = 1'b0;
    i_write = 1'b0;
    i_address = 2'h0;
    i_writedata = 32'h0;
    i_byteenable = 4'h0;
    jumper = 1'b1;
    mdm_en = 1'b1;
    seed = 32'hDA6C819E;
    repeat (5) @(posedge i_clock);
    i_rst_n <= 1'b1;
    rdr(`IDX_RX_CTRL);
    check("rx_ctrl", 16'h0000, rd);
    rdr(`IDX_TX_CTRL);
    check("tx_ctrl", 16'h1080, rd);
    rdr(`IDX_RX_BUF);
    check("rx_buf", 16'h00FF, rd & 16'h40FF);
    rdr(`IDX_TX_BUF);
    check("unmapped", 16'h0000, rd);
    exp_rc = 16'h0000;
    repeat (24) begin
      seed = xs(seed);
      wr(`IDX_RX_CTRL, seed[15:0], seed[19:16]);
      exp_rc = (exp_rc & ~(`RC_WMASK & lanes(seed[19:16]))) | (seed[15:0] & `RC_WMASK & lanes(seed[19:16]));
      rdr(`IDX_RX_CTRL);
      check("rx_ctrl", exp_rc, rd & `RC_WMASK);
      check("modem_ctrl", exp_rc & `RC_MODEM, {13'h0, rts, dtr, 1'b0});
    end
    wr(`IDX_TX_CTRL, 16'h0420, 4'h1);
    wr(`IDX_TX_CTRL, 16'h0400, 4'h2);
    rdr(`IDX_TX_CTRL);
    check("tx_ctrl", 16'h14A0, rd);
    wr(`IDX_RX_CTRL, 16'h0006, 4'h1);
    jumper <= 1'b0;
    mrst();
    rdr(`IDX_RX_CTRL);
    check("rx_ctrl", 16'h0006, rd);
    rdr(`IDX_TX_CTRL);
    check("tx_ctrl", 16'h1080, rd);
    jumper <= 1'b1;
    mrst();
    rdr(`IDX_RX_CTRL);
    check("rx_ctrl", 16'h0000, rd);
    for (int v = 0; v < 2; v++) begin
      wr(`IDX_TX_CTRL, 16'h0604 | 16'(v), 4'h3);
      rdr(`IDX_TX_CTRL);
      check("rx_monitor", 16'(v), {15'h0, rd[`TC_RXMON]});
    end
    for (int k = 0; k < 2; k++) begin
      wr(`IDX_TX_CTRL, k ? 16'h0002 : 16'h000A, 4'h1);
      rdr(`IDX_TX_CTRL);
      check("loop_clock", 16'(k == 0), {15'h0, lclk});
    end
    for (int m = 0; m < 2; m++) begin
      mrst();
      wr(`IDX_PARAM, 16'h0300, 4'hF);
      wr(`IDX_RX_CTRL, 16'h0050, 4'h1);
      wr(`IDX_TX_CTRL, m ? 16'h001C : 16'h0010, 4'h1);
      for (int j = 0; j < 3; j++) begin
        seed = xs(seed);
        ch = seed[7:0];
        wr(`IDX_TX_BUF, {8'h00, ch}, 4'h1);
        if (j < 2) wait_rx();
        else repeat (300) @(posedge i_clock);
        if (j == 0) begin
          check("rx_irq", 16'h0001, {15'h0, irq});
          rdr(`IDX_RX_BUF);
          check("rx_buf", {8'h00, ch}, rd & 16'h40FF);
        end
      end
      rdr(`IDX_RX_BUF);
      check("rx_buf", {2'b01, 6'h00, ch}, rd & 16'h40FF);
    end
    mrst();
    wr(`IDX_PARAM, 16'h1396, 4'hF);
    wr(`IDX_RX_CTRL, 16'h0010, 4'h1);
    wr(`IDX_TX_CTRL, 16'h001C, 4'h1);
    wait_rx();
    rdr(`IDX_RX_BUF);
    check("rx_buf", 16'h0096, rd & 16'h00FF);
    for (int k = 0; k < 2; k++) begin
      mrst();
      wr(`IDX_PARAM, 16'h0300, 4'hF);
      wr(`IDX_RX_CTRL, k ? 16'h0010 : 16'h0000, 4'h1);
      wr(`IDX_TX_CTRL, k ? 16'h0030 : 16'h001C, 4'h1);
      wr(`IDX_TX_BUF, 16'h005A, 4'h1);
      repeat (300) @(posedge i_clock);
      rdr(`IDX_RX_CTRL);
      check("rx_done", 16'h0000, {15'h0, rd[`RC_RXDONE]});
    end
    wr(`IDX_TX_CTRL, 16'h0000, 4'h1);
    wr(`IDX_TX_BUF, 16'h0033, 4'h1);
    rdr(`IDX_TX_CTRL);
    check("tx_done", 16'h0080, rd & 16'h0080);
    repeat (300) @(posedge i_clock);
    check("line", 16'h0001, {15'h0, ser_out});
    results();
  end
endmodule : sync_serial_line_interface_tb
`default_nettype wire
